// >>> hw/afe_trim_pkg.sv
package afe_trim_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam int unsigned  ADDR_W                  = 4;
    localparam logic [3:0]   OFF_CMP1_TRIM           = 4'h0;
    localparam logic [3:0]   OFF_CMP_POL_HYS         = 4'h1;
    localparam logic [3:0]   OFF_AMP_CTRL            = 4'h2;
    localparam logic [3:0]   OFF_AMP_TRIM            = 4'h3;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0]   RST_CMP1_TRIM           = 8'h10;
    localparam logic [7:0]   RST_CMP_POL_HYS         = 8'h00;
    localparam logic [7:0]   RST_AMP_CTRL            = 8'h00;
    localparam logic [7:0]   RST_AMP_TRIM            = 8'h20;
    localparam logic [7:0]   READ_IDLE               = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned  CMP1_TOP_BIT            = 7;
    localparam int unsigned  CMP1_MODE_BIT           = 6;
    localparam int unsigned  CMP1_REF_BIT            = 5;
    localparam int unsigned  CMP1_TRIM_W             = 5;
    localparam int unsigned  CMP_SEL_BIT             = 6;
    localparam int unsigned  CMP1_INV_BIT            = 5;
    localparam int unsigned  CMP0_INV_BIT            = 4;
    localparam int unsigned  CMP1_HYS_LSB            = 2;
    localparam int unsigned  CMP0_HYS_LSB            = 0;
    localparam int unsigned  HYS_W                   = 2;
    localparam int unsigned  AMP_EN_BIT              = 6;
    localparam int unsigned  AMP_STATUS_BIT          = 5;
    localparam int unsigned  AMP_BW_BIT              = 0;
    localparam int unsigned  AMP_MODE_BIT            = 7;
    localparam int unsigned  AMP_REF_BIT             = 6;
    localparam int unsigned  AMP_TRIM_W              = 6;

endpackage : afe_trim_pkg

// >>> hw/cmp_output_stage.sv
`timescale 1ns/10ps
module cmp_output_stage
    import afe_trim_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  reset,
    input  wire logic  cmp0_raw,
    input  wire logic  cmp1_raw,
    input  wire logic  cmp0_debounced,
    input  wire logic  cmp1_debounced,
    input  wire logic  cmp0_invert,
    input  wire logic  cmp1_invert,
    input  wire logic  cmp_output_select,
    output logic       cmp0_status,
    output logic       cmp1_status,
    output logic       cmp_output
);

    // ************************************************************
    // polarity of each comparator status
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp0_status <= 1'b0;
            cmp1_status <= 1'b0;
        end else begin
            cmp0_status <= cmp0_raw ^ cmp0_invert; // [RQ7]
            cmp1_status <= cmp1_raw ^ cmp1_invert; // [RQ6]
        end
    end

    // ************************************************************
    // common output selection
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp_output <= 1'b0;
        end else begin
            cmp_output <= cmp_output_select ? cmp1_debounced
                                            : cmp0_debounced; // [RQ5]
        end
    end

endmodule : cmp_output_stage

// >>> hw/analog_frontend_trim_control_regs.sv
// What this block does
// RQ1 - comparator 1 trim register top bit has no storage, reads zero
// RQ2 - comparator 1 mode bit: 0 normal, 1 offset calibration
// RQ3 - comparator 1 reference bit: 0 negative input, 1 positive input
// RQ4 - comparator 1 five-bit trim field in low bits, read/write, drives trim
// RQ5 - output select bit: 0 comparator 0 debounced, 1 comparator 1
// RQ6 - comparator 1 polarity bit inverts its status when set
// RQ7 - comparator 0 polarity bit inverts its status when set
// RQ8 - two 2-bit hysteresis fields, comparator 1 upper, comparator 0 lowest
// RQ9 - amplifier enable bit: 0 disabled, 1 enabled
// RQ10 - amplifier status read-only, shows amplifier output in calibration
// RQ11 - amplifier status reads zero outside calibration mode
// RQ12 - bandwidth bit: 0 selects 600 kHz, 1 selects 2 MHz
// RQ13 - amplifier trim register top bit: 0 normal, 1 offset calibration
// RQ14 - amplifier reference bit: 0 negative input, 1 positive input
// RQ15 - amplifier six-bit trim field in low bits, read/write, drives trim
// RQ16 - software sweeps trim up and down, writes truncated average
// RQ17 - writes to status and unimplemented bits are ignored
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps
module analog_frontend_trim_control_regs
    import afe_trim_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        reset,
    input  wire logic [afe_trim_pkg::ADDR_W-1:0] addr,
    input  wire logic [7:0]                  wr_data,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [7:0]                  rd_data,
    input  wire logic                        cmp0_raw,
    input  wire logic                        cmp1_raw,
    input  wire logic                        cmp0_debounced,
    input  wire logic                        cmp1_debounced,
    input  wire logic                        amp_output,
    output logic                             cmp1_cal_mode,
    output logic                             cmp1_cal_ref_select,
    output logic      [afe_trim_pkg::CMP1_TRIM_W-1:0] cmp1_trim_value,
    output logic                             cmp_output_select,
    output logic                             cmp1_invert,
    output logic                             cmp0_invert,
    output logic      [afe_trim_pkg::HYS_W-1:0] cmp1_hysteresis,
    output logic      [afe_trim_pkg::HYS_W-1:0] cmp0_hysteresis,
    output logic                             cmp0_status,
    output logic                             cmp1_status,
    output logic                             cmp_output,
    output logic                             amp_enable,
    output logic                             amp_bandwidth_select,
    output logic                             amp_cal_mode,
    output logic                             amp_cal_ref_select,
    output logic      [afe_trim_pkg::AMP_TRIM_W-1:0] amp_trim_value
);

    import afe_trim_pkg::*;

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic  wr_cmp1;
    logic  wr_pol;
    logic  wr_actl;
    logic  wr_atrm;
    logic  amp_status;

    assign wr_cmp1    = wr_en && hit(addr, OFF_CMP1_TRIM);
    assign wr_pol     = wr_en && hit(addr, OFF_CMP_POL_HYS);
    assign wr_actl    = wr_en && hit(addr, OFF_AMP_CTRL);
    assign wr_atrm    = wr_en && hit(addr, OFF_AMP_TRIM);
    assign amp_status = amp_cal_mode & amp_output; // [RQ10] [RQ11]

    // ************************************************************
    // comparator 1 trim register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp1_cal_mode       <= RST_CMP1_TRIM[CMP1_MODE_BIT];
            cmp1_cal_ref_select <= RST_CMP1_TRIM[CMP1_REF_BIT];
            cmp1_trim_value     <= RST_CMP1_TRIM[CMP1_TRIM_W-1:0];
        end else if (wr_cmp1) begin
            cmp1_cal_mode       <= wr_data[CMP1_MODE_BIT]; // [RQ2]
            cmp1_cal_ref_select <= wr_data[CMP1_REF_BIT]; // [RQ3]
            cmp1_trim_value     <= wr_data[CMP1_TRIM_W-1:0]; // [RQ4]
        end
    end

    // ************************************************************
    // shared comparator polarity and hysteresis register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmp_output_select <= RST_CMP_POL_HYS[CMP_SEL_BIT];
            cmp1_invert       <= RST_CMP_POL_HYS[CMP1_INV_BIT];
            cmp0_invert       <= RST_CMP_POL_HYS[CMP0_INV_BIT];
            cmp1_hysteresis   <= RST_CMP_POL_HYS[CMP1_HYS_LSB +: HYS_W];
            cmp0_hysteresis   <= RST_CMP_POL_HYS[CMP0_HYS_LSB +: HYS_W];
        end else if (wr_pol) begin
            cmp_output_select <= wr_data[CMP_SEL_BIT]; // [RQ5]
            cmp1_invert       <= wr_data[CMP1_INV_BIT]; // [RQ6]
            cmp0_invert       <= wr_data[CMP0_INV_BIT]; // [RQ7]
            cmp1_hysteresis   <= wr_data[CMP1_HYS_LSB +: HYS_W]; // [RQ8]
            cmp0_hysteresis   <= wr_data[CMP0_HYS_LSB +: HYS_W]; // [RQ8]
        end
    end

    // ************************************************************
    // amplifier control register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            amp_enable           <= RST_AMP_CTRL[AMP_EN_BIT];
            amp_bandwidth_select <= RST_AMP_CTRL[AMP_BW_BIT];
        end else if (wr_actl) begin
            // status and unused bits of the write are dropped [RQ17]
            amp_enable           <= wr_data[AMP_EN_BIT]; // [RQ9]
            amp_bandwidth_select <= wr_data[AMP_BW_BIT]; // [RQ12]
        end
    end

    // ************************************************************
    // amplifier trim register
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            amp_cal_mode       <= RST_AMP_TRIM[AMP_MODE_BIT];
            amp_cal_ref_select <= RST_AMP_TRIM[AMP_REF_BIT];
            amp_trim_value     <= RST_AMP_TRIM[AMP_TRIM_W-1:0];
        end else if (wr_atrm) begin
            amp_cal_mode       <= wr_data[AMP_MODE_BIT]; // [RQ13]
            amp_cal_ref_select <= wr_data[AMP_REF_BIT]; // [RQ14]
            amp_trim_value     <= wr_data[AMP_TRIM_W-1:0]; // [RQ15]
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [7:0] next_rd_data;

    always_comb begin
        next_rd_data = READ_IDLE;
        if (rd_en) begin
            case (addr)
                OFF_CMP1_TRIM: begin
                    // top bit has no storage [RQ1]
                    next_rd_data[CMP1_MODE_BIT]       = cmp1_cal_mode;
                    next_rd_data[CMP1_REF_BIT]        = cmp1_cal_ref_select;
                    next_rd_data[CMP1_TRIM_W-1:0]     = cmp1_trim_value;
                end
                OFF_CMP_POL_HYS: begin
                    next_rd_data[CMP_SEL_BIT]           = cmp_output_select;
                    next_rd_data[CMP1_INV_BIT]          = cmp1_invert;
                    next_rd_data[CMP0_INV_BIT]          = cmp0_invert;
                    next_rd_data[CMP1_HYS_LSB +: HYS_W] = cmp1_hysteresis;
                    next_rd_data[CMP0_HYS_LSB +: HYS_W] = cmp0_hysteresis;
                end
                OFF_AMP_CTRL: begin
                    next_rd_data[AMP_EN_BIT]     = amp_enable;
                    next_rd_data[AMP_STATUS_BIT] = amp_status; // [RQ10]
                    next_rd_data[AMP_BW_BIT]     = amp_bandwidth_select;
                end
                OFF_AMP_TRIM: begin
                    next_rd_data[AMP_MODE_BIT]     = amp_cal_mode;
                    next_rd_data[AMP_REF_BIT]      = amp_cal_ref_select;
                    next_rd_data[AMP_TRIM_W-1:0]   = amp_trim_value;
                end
                default: begin
                    next_rd_data = READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_data <= READ_IDLE;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ************************************************************
    // comparator status and output stage
    // ************************************************************
    cmp_output_stage u_stage (
        .ref_clk           (ref_clk),
        .reset             (reset),
        .cmp0_raw          (cmp0_raw),
        .cmp1_raw          (cmp1_raw),
        .cmp0_debounced    (cmp0_debounced),
        .cmp1_debounced    (cmp1_debounced),
        .cmp0_invert       (cmp0_invert),
        .cmp1_invert       (cmp1_invert),
        .cmp_output_select (cmp_output_select),
        .cmp0_status       (cmp0_status),
        .cmp1_status       (cmp1_status),
        .cmp_output        (cmp_output)
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_cmp1_top_zero: assert property ( // [RQ1]
        @(posedge ref_clk) disable iff (reset)
        wr_cmp1 && wr_data[CMP1_TOP_BIT] ##1 rd_en && hit(addr, OFF_CMP1_TRIM)
        |=> rd_data[CMP1_TOP_BIT] == 1'b0)
        else $error("comparator 1 trim top bit read nonzero");

    a_cmp1_mode_wr: assert property ( // [RQ2]
        @(posedge ref_clk) disable iff (reset)
        wr_cmp1 |=> cmp1_cal_mode == $past(wr_data[CMP1_MODE_BIT]))
        else $error("comparator 1 mode not written");

    a_cmp1_ref_rb: assert property ( // [RQ3]
        @(posedge ref_clk) disable iff (reset)
        wr_cmp1 ##1 rd_en && hit(addr, OFF_CMP1_TRIM)
        |=> rd_data[CMP1_REF_BIT] == $past(wr_data[CMP1_REF_BIT], 2))
        else $error("comparator 1 reference readback wrong");

    a_cmp1_trim_rb: assert property ( // [RQ4]
        @(posedge ref_clk) disable iff (reset)
        wr_cmp1 ##1 (!wr_cmp1 && rd_en && hit(addr, OFF_CMP1_TRIM))
        |=> rd_data[CMP1_TRIM_W-1:0] == $past(wr_data[CMP1_TRIM_W-1:0], 2)
            && cmp1_trim_value == $past(wr_data[CMP1_TRIM_W-1:0], 2))
        else $error("comparator 1 trim readback wrong");

    a_out_select: assert property ( // [RQ5]
        @(posedge ref_clk) disable iff (reset)
        wr_pol ##1 (!wr_pol && cmp1_debounced != cmp0_debounced)
        |=> cmp_output == ($past(wr_data[CMP_SEL_BIT], 2)
                           ? $past(cmp1_debounced) : $past(cmp0_debounced)))
        else $error("common comparator output selection wrong");

    a_cmp1_polarity: assert property ( // [RQ6]
        @(posedge ref_clk) disable iff (reset)
        wr_pol ##1 !wr_pol
        |=> cmp1_status == ($past(cmp1_raw) ^ $past(wr_data[CMP1_INV_BIT], 2)))
        else $error("comparator 1 polarity wrong");

    a_cmp0_polarity: assert property ( // [RQ7]
        @(posedge ref_clk) disable iff (reset)
        wr_pol ##1 !wr_pol
        |=> cmp0_status == ($past(cmp0_raw) ^ $past(wr_data[CMP0_INV_BIT], 2)))
        else $error("comparator 0 polarity wrong");

    a_hys_fields: assert property ( // [RQ8]
        @(posedge ref_clk) disable iff (reset)
        wr_pol |=> cmp1_hysteresis == $past(wr_data[CMP1_HYS_LSB +: HYS_W])
                   && cmp0_hysteresis == $past(wr_data[CMP0_HYS_LSB +: HYS_W]))
        else $error("hysteresis fields misplaced");

    a_amp_enable: assert property ( // [RQ9]
        @(posedge ref_clk) disable iff (reset)
        wr_actl |=> amp_enable == $past(wr_data[AMP_EN_BIT]))
        else $error("amplifier enable not written");

    a_amp_status_on: assert property ( // [RQ10]
        @(posedge ref_clk) disable iff (reset)
        rd_en && hit(addr, OFF_AMP_CTRL) && amp_cal_mode
        |=> rd_data[AMP_STATUS_BIT] == $past(amp_output))
        else $error("amplifier status does not follow output");

    a_amp_status_off: assert property ( // [RQ11]
        @(posedge ref_clk) disable iff (reset)
        rd_en && hit(addr, OFF_AMP_CTRL) && !amp_cal_mode
        |=> rd_data[AMP_STATUS_BIT] == 1'b0)
        else $error("amplifier status not zero outside calibration");

    a_amp_bw_rb: assert property ( // [RQ12]
        @(posedge ref_clk) disable iff (reset)
        wr_actl ##1 rd_en && hit(addr, OFF_AMP_CTRL)
        |=> rd_data[AMP_BW_BIT] == $past(wr_data[AMP_BW_BIT], 2))
        else $error("bandwidth readback wrong");

    a_amp_mode_wr: assert property ( // [RQ13]
        @(posedge ref_clk) disable iff (reset)
        wr_atrm |=> amp_cal_mode == $past(wr_data[AMP_MODE_BIT]))
        else $error("amplifier mode not written");

    a_amp_ref_wr: assert property ( // [RQ14]
        @(posedge ref_clk) disable iff (reset)
        wr_atrm |=> amp_cal_ref_select == $past(wr_data[AMP_REF_BIT]))
        else $error("amplifier reference not written");

    a_amp_trim_hold: assert property ( // [RQ15]
        @(posedge ref_clk) disable iff (reset)
        wr_atrm ##1 !wr_atrm[*2]
        |-> amp_trim_value == $past(wr_data[AMP_TRIM_W-1:0], 2))
        else $error("amplifier trim not kept");

    a_ctrl_unused: assert property ( // [RQ17]
        @(posedge ref_clk) disable iff (reset)
        wr_actl ##1 rd_en && hit(addr, OFF_AMP_CTRL)
        |=> rd_data[7] == 1'b0 && rd_data[4:1] == 4'h0
            && amp_enable == $past(wr_data[AMP_EN_BIT], 2))
        else $error("unused amplifier control bits not ignored");

    a_read_idle: assert property (
        @(posedge ref_clk) disable iff (reset)
        !rd_en |=> rd_data == READ_IDLE)
        else $error("read data not idle outside a read");

endmodule : analog_frontend_trim_control_regs

// >>> dv/test_analog_frontend_trim_control_regs.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
    err_count++; $display("unexpected %s exp %h got %h", nm, ex, gt); end end

module test_analog_frontend_trim_control_regs;
    import afe_trim_pkg::*;

    // ************************************************************
    // signals
    // ************************************************************
    logic                  ref_clk, reset, wr_en, rd_en;
    logic [ADDR_W-1:0]     addr;
    logic [7:0]            wr_data, rd_data, got;
    logic                  cmp0_raw, cmp1_raw, cmp0_debounced, cmp1_debounced;
    logic                  amp_output, cmp1_cal_mode, cmp1_cal_ref_select;
    logic [CMP1_TRIM_W-1:0] cmp1_trim_value;
    logic                  cmp_output_select, cmp1_invert, cmp0_invert;
    logic [HYS_W-1:0]      cmp1_hysteresis, cmp0_hysteresis;
    logic                  cmp0_status, cmp1_status, cmp_output;
    logic                  amp_enable, amp_bandwidth_select;
    logic                  amp_cal_mode, amp_cal_ref_select;
    logic [AMP_TRIM_W-1:0] amp_trim_value;
    logic [7:0]            m [4];
    logic [7:0]            mask [4] = '{8'h7f, 8'h7f, 8'h41, 8'hff};
    logic [19:0]           rows [13] = '{20'h0_ff_7f, 20'h0_95_15,
        20'h0_40_40, 20'h1_ff_7f, 20'h1_a6_26, 20'h2_ff_41, 20'h2_be_00,
        20'h2_01_01, 20'h3_c0_c0, 20'h3_3f_3f, 20'h3_ff_ff, 20'h4_ff_00,
        20'hf_5a_00};
    int                    err_count, n_checks, v_up, v_down;

    analog_frontend_trim_control_regs analog_frontend_trim_control_regs_i (
        .ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .cmp0_raw(cmp0_raw), .cmp1_raw(cmp1_raw),
        .cmp0_debounced(cmp0_debounced), .cmp1_debounced(cmp1_debounced),
        .amp_output(amp_output), .cmp1_cal_mode(cmp1_cal_mode),
        .cmp1_cal_ref_select(cmp1_cal_ref_select),
        .cmp1_trim_value(cmp1_trim_value),
        .cmp_output_select(cmp_output_select), .cmp1_invert(cmp1_invert),
        .cmp0_invert(cmp0_invert), .cmp1_hysteresis(cmp1_hysteresis),
        .cmp0_hysteresis(cmp0_hysteresis), .cmp0_status(cmp0_status),
        .cmp1_status(cmp1_status), .cmp_output(cmp_output),
        .amp_enable(amp_enable),
        .amp_bandwidth_select(amp_bandwidth_select),
        .amp_cal_mode(amp_cal_mode), .amp_cal_ref_select(amp_cal_ref_select),
        .amp_trim_value(amp_trim_value)
    );

    // ************************************************************
    // bus tasks and model
    // ************************************************************
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        if (a < 4) m[a[1:0]] = d & mask[a[1:0]];
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        d = rd_data;
    endtask : rd

    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        if (a < 4) m[a[1:0]] = d & mask[a[1:0]];
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        got = rd_data;
    endtask : wr_rd

    // amplifier model flips its output between trim 22 and 23
    task automatic sweep_trim(input int start, input int step, output int at);
        logic first;
        at = -1;
        for (int t = start; t >= 0 && t < 64 && at < 0; t += step) begin
            wr(OFF_AMP_TRIM, 8'h80 | 8'(t));
            amp_output <= (t >= 23);
            rd(OFF_AMP_CTRL, got);
            if (t == start) first = got[AMP_STATUS_BIT];
            else if (got[AMP_STATUS_BIT] !== first) at = t;
        end
    endtask : sweep_trim

    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        if (a == OFF_AMP_CTRL)
            return m[2] | {2'b00, m[3][7] & amp_output, 5'h00};
        return (a < 4) ? m[a[1:0]] : READ_IDLE;
    endfunction : exp_rd

    task automatic chk_reg(input logic [3:0] a);
        rd(a, got);
        `CHK("rd_data", exp_rd(a), got)
    endtask : chk_reg

    task automatic reset_model();
        m[0] = RST_CMP1_TRIM;
        m[1] = RST_CMP_POL_HYS;
        m[2] = RST_AMP_CTRL;
        m[3] = RST_AMP_TRIM;
    endtask : reset_model

    task automatic check_fields();
        `CHK("cmp1_cal_mode", m[0][6], cmp1_cal_mode)
        `CHK("cmp1_cal_ref_select", m[0][5], cmp1_cal_ref_select)
        `CHK("cmp1_trim_value", m[0][4:0], cmp1_trim_value)
        `CHK("cmp_output_select", m[1][6], cmp_output_select)
        `CHK("cmp1_invert", m[1][5], cmp1_invert)
        `CHK("cmp0_invert", m[1][4], cmp0_invert)
        `CHK("cmp1_hysteresis", m[1][3:2], cmp1_hysteresis)
        `CHK("cmp0_hysteresis", m[1][1:0], cmp0_hysteresis)
        `CHK("amp_enable", m[2][6], amp_enable)
        `CHK("amp_bandwidth_select", m[2][0], amp_bandwidth_select)
        `CHK("amp_cal_mode", m[3][7], amp_cal_mode)
        `CHK("amp_cal_ref_select", m[3][6], amp_cal_ref_select)
        `CHK("amp_trim_value", m[3][5:0], amp_trim_value)
    endtask : check_fields

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // ************************************************************
    // clock and watchdog
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {reset, wr_en, rd_en, addr, wr_data} = {1'b1, 2'b00, 4'h0, 8'h00};
        {cmp0_raw, cmp1_raw, cmp0_debounced, cmp1_debounced} = 4'h0;
        amp_output = 1'b0;
        reset_model();
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 5; i++) chk_reg(4'(i));
        check_fields();
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16], got);
            `CHK("row read", rows[i][7:0], got)
            check_fields();
        end
        for (int i = 0; i < 4; i++) chk_reg(4'(i));
        // amplifier status follows its output only in calibration mode
        wr(OFF_AMP_TRIM, 8'h80);
        @(posedge ref_clk) amp_output <= 1'b1;
        chk_reg(OFF_AMP_CTRL);
        `CHK("amp status", 1'b1, got[AMP_STATUS_BIT])
        @(posedge ref_clk) amp_output <= 1'b0;
        chk_reg(OFF_AMP_CTRL);
        wr(OFF_AMP_TRIM, 8'h25);
        @(posedge ref_clk) amp_output <= 1'b1;
        chk_reg(OFF_AMP_CTRL);
        `CHK("amp status off", 1'b0, got[AMP_STATUS_BIT])
        // write then read with no gap, then idle read data
        wr_rd(OFF_CMP1_TRIM, 8'h8a);
        `CHK("rd_data b2b", 8'h0a, got)
        @(negedge ref_clk);
        `CHK("rd_data idle", READ_IDLE, rd_data)
        wr_rd(OFF_AMP_CTRL, 8'hbf);
        `CHK("ctrl b2b", 8'h01, got)
        // calibration sweep up and down, then the truncated average
        sweep_trim(0, 1, v_up);
        sweep_trim(63, -1, v_down);
        `CHK("sweep up", 23, v_up)
        `CHK("sweep down", 22, v_down)
        wr(OFF_AMP_TRIM, 8'((v_up + v_down) / 2));
        @(negedge ref_clk);
        `CHK("cal trim", 6'd22, amp_trim_value)
        // polarity, output select and hysteresis over all 32 values of k
        for (int k = 0; k < 32; k++) begin
            @(posedge ref_clk);
            cmp0_raw       <= k[0];
            cmp1_raw       <= k[1];
            cmp0_debounced <= k[1];
            cmp1_debounced <= ~k[1];
            wr(OFF_CMP_POL_HYS, {1'b0, k[4:2], k[3:0]});
            repeat (2) @(posedge ref_clk);
            @(negedge ref_clk);
            `CHK("cmp0_status", k[0] ^ k[2], cmp0_status)
            `CHK("cmp1_status", k[1] ^ k[3], cmp1_status)
            `CHK("cmp_output", k[1] ^ k[4], cmp_output)
            check_fields();
        end
        // reset in mid-run restores every register
        wr(OFF_CMP1_TRIM, 8'h7f);
        wr(OFF_AMP_CTRL, 8'h41);
        wr(OFF_AMP_TRIM, 8'hc5);
        @(posedge ref_clk) reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reset_model();
        for (int i = 0; i < 4; i++) chk_reg(4'(i));
        check_fields();
        test_done();
    end

endmodule : test_analog_frontend_trim_control_regs
